// >>> hw/lcdcd_pkg.sv
package lcdcd_pkg;

  localparam int DOT_W = 6;
  localparam int DOTS_PER_PIX = 3;
  localparam int PIX_W = DOT_W * DOTS_PER_PIX;

  // slots of the data register in each output mode
  localparam logic [6:0] PIX_309 = 7'd103;
  localparam logic [6:0] PIX_300 = 7'd100;
  // shift clocks after the start pulse at which loading ends
  localparam logic [6:0] STOP_309 = 7'd105;
  localparam logic [6:0] STOP_300 = 7'd102;
  localparam logic [6:0] CNT_ONE = 7'd1;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LINES = 8'h08;

  // control register field
  localparam int CTRL_BLANK_BIT = 0;
  localparam logic CTRL_RESET = 1'b0;

  // status register fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_COUNT_LSB = 8;
  localparam int ST_MODE_BIT = 16;
  localparam int ST_DIR_BIT = 17;
  localparam int ST_CASC_BIT = 18;
  localparam int ST_DRIVE_BIT = 19;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [DOT_W-1:0] dot2;
    logic [DOT_W-1:0] dot1;
    logic [DOT_W-1:0] first_dot_data;
  } lcdcd_pixel_s;

  // gray codes along idle -> load -> done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_DONE = 2'b11
  } lcdcd_state_e;

endpackage

// >>> hw/lcdcd_top.sv
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - direction high: shift first to last, right start pin is input; low reverses
// - right shift: right pin input, left pin output; left shift swaps roles
// - loading starts when start input is high at a shift clock rise
// - each shift clock rise while loading stores the pixel in the next slot until 103 (309 mode) or 100 (300 mode) are filled
// - start output rises at clock 103 (309 mode) or 100 (300 mode)
// - loading stops after 105 clocks (309 mode) or 102 (300 mode)
// - strobe rising edge clears the shift register for the next line
// - strobe rising edge copies the data register into the output latch
// - strobe falling edge drives latched gray levels onto the columns
// - count select low gives 309 outputs, high gives 300, counts follow
// - swap low: odd columns lower set, even upper; high swaps the sets
// - complement select high inverts incoming data, low leaves it unchanged
// - low-power input high cuts output buffer bias; open pin means low power
module lcdcd_top #(
  parameter int PIX = 103,
  parameter int COLS = 309
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic shift_clk,
  input wire lcdcd_pkg::lcdcd_pixel_s pixel_in,
  input wire logic direction_select,
  input wire logic output_count_select,
  input wire logic right_side_start_pulse_in,
  output logic right_side_start_pulse_out,
  output logic right_side_start_pulse_oe_n,
  input wire logic left_side_start_pulse_in,
  output logic left_side_start_pulse_out,
  output logic left_side_start_pulse_oe_n,
  input wire logic line_latch_strobe,
  input wire logic reference_half_swap,
  input wire logic data_complement_select,
  input wire logic low_power_control,
  output logic [COLS*lcdcd_pkg::DOT_W-1:0] column_outputs,
  output logic [COLS-1:0] column_upper_ref,
  output logic column_drive_enable,
  output logic buffer_bias_enable,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import lcdcd_pkg::*;

  lcdcd_state_e state;
  logic sck_q;
  logic stb_q;
  logic sck_rise;
  logic stb_rise;
  logic stb_fall;
  logic [6:0] cnt;
  logic [6:0] next_cnt;
  logic [6:0] npix;
  logic [6:0] nstop;
  logic [6:0] slot;
  logic start_seen;
  logic cascade_pulse;
  logic [PIX_W-1:0] incoming;
  logic [PIX_W-1:0] data_reg [PIX];
  logic [PIX_W-1:0] latch_reg [PIX];
  logic [PIX_W-1:0] drive_reg [PIX];
  logic drive_swap;
  logic drive_valid;
  logic blank;
  logic [15:0] line_count;

  // pins are synchronous to aclk, so edges come from one delay stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_q <= 1'b0;
      stb_q <= 1'b0;
    end else begin
      sck_q <= shift_clk;
      stb_q <= line_latch_strobe;
    end
  end

  assign sck_rise = shift_clk & ~sck_q;
  assign stb_rise = line_latch_strobe & ~stb_q;
  assign stb_fall = ~line_latch_strobe & stb_q;

  assign npix = output_count_select ? PIX_300 : PIX_309;
  assign nstop = output_count_select ? STOP_300 : STOP_309;
  assign start_seen = direction_select ? right_side_start_pulse_in : left_side_start_pulse_in;
  assign next_cnt = cnt + CNT_ONE;
  // right shift fills from the first column, left shift from the last in use
  assign slot = direction_select ? cnt : 7'(npix - CNT_ONE - cnt);
  assign incoming = data_complement_select ? ~PIX_W'(pixel_in) : PIX_W'(pixel_in);

  // line sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      cnt <= '0;
    end else if (stb_rise) begin
      state <= ST_IDLE;
      cnt <= '0;
    end else if (sck_rise) begin
      case (state)
        ST_IDLE: begin
          if (start_seen) begin
            state <= ST_LOAD;
            cnt <= '0;
          end
        end
        ST_LOAD: begin
          cnt <= next_cnt;
          if (next_cnt == nstop) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_DONE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // cascade start pulse, one shift clock period wide
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cascade_pulse <= 1'b0;
    end else if (stb_rise) begin
      cascade_pulse <= 1'b0;
    end else if (sck_rise) begin
      cascade_pulse <= (state == ST_LOAD) && (next_cnt == npix);
    end
  end

  assign right_side_start_pulse_out = cascade_pulse;
  assign left_side_start_pulse_out = cascade_pulse;
  // enable low while driving: the pin away from the input drives
  assign right_side_start_pulse_oe_n = direction_select;
  assign left_side_start_pulse_oe_n = ~direction_select;

  // data register, output latch and drive stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < PIX; i++) begin
        data_reg[i] <= '0;
        latch_reg[i] <= '0;
      end
    end else if (stb_rise) begin
      for (int i = 0; i < PIX; i++) begin
        latch_reg[i] <= data_reg[i];
        data_reg[i] <= '0;
      end
    end else if (sck_rise && state == ST_LOAD && cnt < npix) begin
      data_reg[slot] <= incoming;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < PIX; i++) begin
        drive_reg[i] <= '0;
      end
      drive_swap <= 1'b0;
      drive_valid <= 1'b0;
    end else if (stb_fall) begin
      for (int i = 0; i < PIX; i++) begin
        drive_reg[i] <= latch_reg[i];
      end
      // polarity taken late so its setup after strobe rise is honoured
      drive_swap <= reference_half_swap;
      drive_valid <= 1'b1;
    end
  end

  generate
    for (genvar c = 0; c < COLS; c++) begin : g_col
      assign column_outputs[c*DOT_W +: DOT_W] = drive_reg[c / DOTS_PER_PIX][(c % DOTS_PER_PIX)*DOT_W +: DOT_W];
      // column c drives output c+1, so even c is an odd-numbered output
      assign column_upper_ref[c] = ((c % 2) == 1) ^ drive_swap;
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      column_drive_enable <= 1'b0;
      buffer_bias_enable <= 1'b0;
    end else begin
      column_drive_enable <= drive_valid & ~blank;
      buffer_bias_enable <= ~low_power_control;
    end
  end

  // register slave
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic lines_clear;
  logic [31:0] status_word;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign lines_clear = do_write && aw_addr == REG_LINES;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr == REG_CTRL || aw_addr == REG_LINES) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blank <= CTRL_RESET;
    end else if (do_write && aw_addr == REG_CTRL && w_strb[0]) begin
      blank <= w_data[CTRL_BLANK_BIT];
    end
  end

  // a strobe in the clearing cycle still counts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_count <= '0;
    end else if (lines_clear) begin
      line_count <= {15'd0, stb_rise};
    end else if (stb_rise) begin
      line_count <= line_count + 16'd1;
    end
  end

  always_comb begin
    status_word = '0;
    status_word[ST_STATE_LSB +: 2] = state;
    status_word[ST_COUNT_LSB +: 7] = cnt;
    status_word[ST_MODE_BIT] = output_count_select;
    status_word[ST_DIR_BIT] = direction_select;
    status_word[ST_CASC_BIT] = cascade_pulse;
    status_word[ST_DRIVE_BIT] = column_drive_enable;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        REG_CTRL: s_axi_rdata <= {31'd0, blank};
        REG_STATUS: s_axi_rdata <= status_word;
        REG_LINES: s_axi_rdata <= {16'd0, line_count};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> verif/lcdcd_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module lcdcd_top_asserts #(
  parameter int COLS = 309
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic direction_select,
  input wire logic right_side_start_pulse_out,
  input wire logic right_side_start_pulse_oe_n,
  input wire logic left_side_start_pulse_out,
  input wire logic left_side_start_pulse_oe_n,
  input wire logic line_latch_strobe,
  input wire logic low_power_control,
  input wire logic [COLS*lcdcd_pkg::DOT_W-1:0] column_outputs,
  input wire logic column_drive_enable,
  input wire logic buffer_bias_enable,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic rst_q;
  // past values still hold reset state on the first edge after release
  always_ff @(posedge aclk) rst_q <= aresetn;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !rst_q);
  pin_role_a: assert property (right_side_start_pulse_oe_n == direction_select &&
    left_side_start_pulse_oe_n == !direction_select)
    else $error("pin role");
  casc_pair_a: assert property (right_side_start_pulse_out == left_side_start_pulse_out)
    else $error("cascade pair");
  casc_len_a: assert property ($rose(right_side_start_pulse_out) |->
    right_side_start_pulse_out[*3] ##[1:3] !right_side_start_pulse_out) else $error("cascade length");
  bias_a: assert property (buffer_bias_enable == !$past(low_power_control))
    else $error("bias");
  col_hold_a: assert property ($changed(column_outputs) |->
    !line_latch_strobe && ($past(line_latch_strobe, 2) || $past(line_latch_strobe, 3))) else $error("columns");
  drive_on_a: assert property ($fell(line_latch_strobe) |-> ##[1:3] column_drive_enable)
    else $error("drive");
  bresp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid");
  rresp_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid");
  cover property ($rose(right_side_start_pulse_out));
  cover property ($fell(line_latch_strobe) ##3 column_drive_enable);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind lcdcd_top lcdcd_top_asserts #(.COLS(COLS)) i_lcdcd_top_asserts (.*);
`default_nettype wire

// >>> verif/lcdcd_tcon_model.sv
`timescale 1ns/100ps
`default_nettype none
module lcdcd_tcon_model (
  input wire logic aclk,
  input wire logic direction_select,
  input wire logic right_side_start_pulse_out,
  input wire logic right_side_start_pulse_oe_n,
  input wire logic left_side_start_pulse_out,
  input wire logic left_side_start_pulse_oe_n,
  output logic shift_clk,
  output lcdcd_pkg::lcdcd_pixel_s pixel_in,
  output logic right_side_start_pulse_in,
  output logic left_side_start_pulse_in,
  output logic line_latch_strobe,
  output logic reference_half_swap
);
  logic start = 1'b0;
  int k_now = 0;
  initial {shift_clk, line_latch_strobe, reference_half_swap, pixel_in} = '0;
  // each pin reads whichever side holds it enabled
  assign right_side_start_pulse_in = right_side_start_pulse_oe_n ? start && direction_select
    : right_side_start_pulse_out;
  assign left_side_start_pulse_in = left_side_start_pulse_oe_n ? start && !direction_select
    : left_side_start_pulse_out;
  task automatic run(input int m);
    logic [5:0] k6;
    for (int k = 0; k <= m; k++) begin
      k6 = k[5:0];
      k_now = k;
      start <= k == 0;
      pixel_in <= {k6 ^ 6'h2a, ~k6, k6};
      shift_clk <= 1'b1;
      repeat (2) @(posedge aclk);
      shift_clk <= 1'b0;
      repeat (2) @(posedge aclk);
    end
    // stale data must not look valid between frames
    pixel_in <= ~pixel_in;
  endtask
  task automatic pulse(input logic s);
    line_latch_strobe <= 1'b1;
    repeat (2) @(posedge aclk);
    reference_half_swap <= s;
    repeat (2) @(posedge aclk);
    line_latch_strobe <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// >>> verif/lcdcd_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module lcdcd_top_tb_top;
  import lcdcd_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic direction_select = 1'b0, output_count_select = 1'b0, data_complement_select = 1'b0;
  logic low_power_control = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
  logic shift_clk, line_latch_strobe, reference_half_swap;
  logic right_side_start_pulse_in, right_side_start_pulse_out, right_side_start_pulse_oe_n;
  logic left_side_start_pulse_in, left_side_start_pulse_out, left_side_start_pulse_oe_n;
  logic column_drive_enable, buffer_bias_enable;
  logic casc_q = 1'b0;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, q;
  lcdcd_pixel_s pixel_in;
  logic [309*DOT_W-1:0] column_outputs;
  logic [308:0] column_upper_ref;
  int n_fail = 0;
  int comparisons = 0;
  int casc_k = -1;
  always #2.5 aclk = ~aclk;
  lcdcd_top i_lcdcd_top (.*);
  lcdcd_tcon_model i_lcdcd_tcon_model (.*);
  always @(posedge aclk) begin
    if (right_side_start_pulse_out && !casc_q) casc_k = i_lcdcd_tcon_model.k_now;
    casc_q <= right_side_start_pulse_out;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(wr ? s_axi_bvalid : s_axi_rvalid));
    q = s_axi_rdata;
    r = wr ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  task automatic run_line(input logic d, input logic o, input logic c);
    int n;
    logic [5:0] k6;
    n = o ? 100 : 103;
    casc_k = -1;
    @(posedge aclk);
    direction_select <= d;
    output_count_select <= o;
    data_complement_select <= c;
    low_power_control <= c;
    @(posedge aclk);
    i_lcdcd_tcon_model.run(n + 3);
    chk("cascade edge", n, casc_k);
    axi(1'b0, REG_STATUS, '0);
    chk("status", {d, o, 2'b11}, {q[17:16], q[1:0]});
    chk("stop count", n + 2, q[14:8]);
    i_lcdcd_tcon_model.pulse(c);
    for (int k = 1; k <= n; k++) begin
      k6 = k[5:0];
      chk("pixel", {k6 ^ 6'h2a, ~k6, k6} ^ {18{c}}, column_outputs[(d ? k - 1 : n - k) * PIX_W +: PIX_W]);
    end
    chk("upper ref", {!c, c}, column_upper_ref[1:0]);
    chk("drive", 1, column_drive_enable);
    chk("bias", !c, buffer_bias_enable);
    if (o) chk("spare", 0, column_outputs[300*DOT_W +: 18]);
    i_lcdcd_tcon_model.pulse(c);
    chk("cleared", 0, |column_outputs);
  endtask
  task automatic reset_check();
    axi(1'b0, REG_STATUS, '0);
    chk("status reset", 0, q);
    chk("bias reset", 0, buffer_bias_enable);
  endtask
  task automatic reg_check();
    axi(1'b0, REG_LINES, '0);
    chk("lines", 4, q);
    axi(1'b1, REG_LINES, '0);
    chk("lines bresp", RESP_OKAY, r);
    axi(1'b0, REG_LINES, '0);
    chk("lines cleared", 0, q);
    // unmapped write must be refused and leave every register alone
    axi(1'b1, 8'h0c, '0);
    chk("unmapped bresp", RESP_SLVERR, r);
    axi(1'b0, 8'h0c, '0);
    chk("unmapped", 2, {q[29:0], r});
    axi(1'b1, REG_CTRL, 1);
    axi(1'b0, REG_CTRL, '0);
    chk("blank", 1, {column_drive_enable, q[0]});
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    reset_check();
    run_line(1'b0, 1'b0, 1'b0);
    run_line(1'b1, 1'b1, 1'b1);
    reg_check();
    tally_and_finish();
  end
  // about five times the expected run
  initial begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
